// File: rtl/adc_control.sv
// Converter control: status/control and result registers, conversion sequencer and shared-pin takeover.
`timescale 1ns/1ps
`include "adc_regs.svh"

//Contract
// - Conversions continue normally during wait mode.
// - Stop mode ceases activity, aborts conversion.
// - Done flag set on fresh result.
// - Done cleared by select, result read, off.
// - Convert repeatedly every 32 clock ticks.
// - New result overwrites old regardless of flag.
// - RC select clocks converter, enables oscillator.
// - Power-on bit enables or disables converter.
// - Control bits 4:3 read as zero.
// - Channel field is low three bits.
// - Channel codes map to pins and references.
// - Reserved channels give undefined results.
// - Selected shared pin stops being digital.
// - Taken pin reads zero when direction input.
// - Taken pin reads latch when direction output.
// - Untaken pins read normally.
// - Result register holds latest conversion value.
module adc_control (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic stop_mode,
  input wire logic rc_tick,
  output logic rc_osc_enable,
  input wire logic comparator_in,
  output logic [7:0] dac_code,
  output logic [2:0] analog_channel,
  output logic sample_hold,
  input wire logic [1:0] port_ddr,
  input wire logic [1:0] port_latch,
  input wire logic [1:0] port_pin,
  output logic [1:0] port_read_data,
  output logic [1:0] port_digital_en
);

  logic rst_meta_q;
  logic rst_sync_n;
  adc_pkg::bus_req_t req;
  adc_pkg::shared_port_t port;
  adc_pkg::ctrl_t ctrl_q;
  adc_pkg::ctrl_t ctrl_rd;
  adc_pkg::conv_state_t state_q;
  logic [4:0] cnt_q;
  logic [7:0] sar_q;
  logic [7:0] sar_next;
  logic [7:0] dac_q;
  logic [7:0] result_q;
  logic [7:0] rdata_q;
  logic sample_q;
  logic [1:0] port_rd_q;
  logic ctrl_wr;
  logic result_rd;
  logic active;
  logic tick;
  logic conv_done;
  logic sar_step;
  logic [1:0] pin_taken;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
  assign port = '{ddr: port_ddr, latch: port_latch, pin: port_pin};

  assign ctrl_wr = req.wr && (req.addr == `ADC_CTRL_OFFSET);
  assign result_rd = req.rd && (req.addr == `ADC_RESULT_OFFSET);

  // Wait mode has no input here on purpose: the converter keeps running through it.
  assign active = ctrl_q.converter_power_on && !stop_mode;
  // The RC tick is assumed already aligned to clk by the oscillator block.
  assign tick = ctrl_q.rc_clock_select ? rc_tick : 1'b1;
  // A control write in the last tick discards that conversion, so the set and a write clear never meet here.
  assign conv_done = (state_q == adc_pkg::ST_RUN) && active && tick && (cnt_q == `ADC_LAST_TICK)
    && !ctrl_wr;
  assign sar_step = (state_q == adc_pkg::ST_RUN) && active && tick && (cnt_q != `ADC_FIRST_TICK)
    && (cnt_q <= `ADC_SAR_STEPS);
  assign sar_next = comparator_in ? dac_q : sar_q;

  // Control fields; the done bit is owned by the sequencer below.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_q.rc_clock_select <= 1'b0;
      ctrl_q.converter_power_on <= 1'b0;
      ctrl_q.unused <= 2'h0;
      ctrl_q.input_channel_field <= 3'h0;
    end
    else if (ctrl_wr)
    begin
      ctrl_q.rc_clock_select <= req.wdata[`ADC_RC_BIT];
      ctrl_q.converter_power_on <= req.wdata[`ADC_ON_BIT];
      ctrl_q.unused <= 2'h0;
      ctrl_q.input_channel_field <= req.wdata[`ADC_CH_MSB:`ADC_CH_LSB];
    end
  end

  // A fresh result beats a clear in the same cycle, so no completion is lost to a racing read.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl_q.done <= 1'b0;
    end
    else if (conv_done)
    begin
      ctrl_q.done <= 1'b1;
    end
    else if (ctrl_wr || result_rd || !ctrl_q.converter_power_on)
    begin
      ctrl_q.done <= 1'b0;
    end
  end

  // Sequencer: tick 0 samples, ticks 1 to 8 approximate, tick 31 publishes.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state_q <= adc_pkg::ST_OFF;
      cnt_q <= `ADC_FIRST_TICK;
    end
    else if (ctrl_wr || !active)
    begin
      state_q <= adc_pkg::ST_OFF;
      cnt_q <= `ADC_FIRST_TICK;
    end
    else
    begin
      unique case (state_q)
        adc_pkg::ST_OFF:
        begin
          state_q <= adc_pkg::ST_RUN;
          cnt_q <= `ADC_FIRST_TICK;
        end
        adc_pkg::ST_RUN:
        begin
          if (tick)
          begin
            cnt_q <= cnt_q + 5'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      sar_q <= 8'h00;
      dac_q <= 8'h00;
      sample_q <= 1'b0;
    end
    else
    begin
      sample_q <= (state_q == adc_pkg::ST_RUN) && active && tick && (cnt_q == `ADC_FIRST_TICK) && !ctrl_wr;
      if (ctrl_wr || !active)
      begin
        sar_q <= 8'h00;
        dac_q <= 8'h00;
      end
      else if ((state_q == adc_pkg::ST_RUN) && tick && (cnt_q == `ADC_FIRST_TICK))
      begin
        sar_q <= 8'h00;
        dac_q <= `ADC_SAR_FIRST;
      end
      else if (sar_step)
      begin
        sar_q <= sar_next;
        dac_q <= sar_next | (`ADC_SAR_FIRST >> cnt_q);
      end
    end
  end

  // Reserved codes are converted like any other; what they yield is undefined by design.
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      result_q <= `ADC_RESULT_RESET;
    end
    else if (conv_done)
    begin
      result_q <= sar_q;
    end
  end

  always_comb
  begin
    ctrl_rd = ctrl_q;
    ctrl_rd.unused = 2'h0;
  end

  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rdata_q <= 8'h00;
    end
    else if (req.rd)
    begin
      unique case (req.addr)
        `ADC_CTRL_OFFSET: rdata_q <= ctrl_rd;
        `ADC_RESULT_OFFSET: rdata_q <= result_q;
        default: rdata_q <= 8'h00;
      endcase
    end
    else
    begin
      rdata_q <= 8'h00;
    end
  end

  // Channels 0 and 1 claim port bits 4 and 5; codes 4 to 7 route to references and test.
  assign pin_taken[0] = ctrl_q.converter_power_on && (ctrl_q.input_channel_field == 3'h0);
  assign pin_taken[1] = ctrl_q.converter_power_on && (ctrl_q.input_channel_field == 3'h1);

  // Registered so the port read mux never sees a half-written channel field.
  port_bit_read low_pin_read (
    .clk(clk),
    .rst_n(rst_sync_n),
    .taken(pin_taken[0]),
    .ddr(port.ddr[0]),
    .latch(port.latch[0]),
    .pin(port.pin[0]),
    .rd_q(port_rd_q[0])
  );

  port_bit_read high_pin_read (
    .clk(clk),
    .rst_n(rst_sync_n),
    .taken(pin_taken[1]),
    .ddr(port.ddr[1]),
    .latch(port.latch[1]),
    .pin(port.pin[1]),
    .rd_q(port_rd_q[1])
  );

  assign bus_rdata = rdata_q;
  assign rc_osc_enable = ctrl_q.rc_clock_select;
  assign dac_code = dac_q;
  assign analog_channel = ctrl_q.input_channel_field;
  assign sample_hold = sample_q;
  assign port_read_data = port_rd_q;
  assign port_digital_en = ~pin_taken;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_sync_n);

  a_done_sets: assert property (conv_done |=> ctrl_q.done)
    else $error("done flag not set after conversion");
  a_done_clr_write: assert property (ctrl_wr |=> !ctrl_q.done)
    else $error("control write did not clear done");
  a_done_clr_read: assert property (result_rd && !conv_done |=> !ctrl_q.done)
    else $error("result read did not clear done");
  a_off_no_done: assert property (!ctrl_q.converter_power_on |=> !ctrl_q.done)
    else $error("done flag high while powered down");
  a_conv_period: assert property (conv_done && !ctrl_q.rc_clock_select |-> $past(cnt_q, 31) == 5'h00)
    else $error("conversion period is not 32 clocks");
  a_stop_abort: assert property (stop_mode |=> state_q == adc_pkg::ST_OFF && !conv_done)
    else $error("conversion continued in stop");
  a_result_load: assert property (conv_done |=> result_q == $past(sar_q))
    else $error("result not overwritten");
  a_reserved_zero: assert property (req.rd && req.addr == `ADC_CTRL_OFFSET |=> bus_rdata[4:3] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_taken_input: assert property (pin_taken[0] && !port.ddr[0] |=> port_read_data[0] == 1'b0)
    else $error("taken input pin read nonzero");
  a_taken_output: assert property (pin_taken[1] && port.ddr[1] |=> port_read_data[1] == $past(port.latch[1]))
    else $error("taken output pin did not read latch");
  a_write_restart: assert property (ctrl_wr |=> !conv_done ##1 (cnt_q == 5'h00))
    else $error("control write did not restart sequence");

  a_done_holds: assert property (ctrl_q.done && !ctrl_wr && !result_rd |=> ctrl_q.done)
    else $error("done flag dropped without a clear");

  a_rc_pace: assert property (state_q == adc_pkg::ST_RUN && active && ctrl_q.rc_clock_select && !rc_tick
    && !ctrl_wr |=> cnt_q == $past(cnt_q))
    else $error("sequencer advanced without an RC tick");

  a_untaken_pin: assert property (!pin_taken[0] && !port.ddr[0] |=> port_read_data[0] == $past(port.pin[0]))
    else $error("free input pin did not read its level");

  a_result_read: assert property (result_rd |=> bus_rdata == $past(result_q))
    else $error("result read returned wrong data");

  a_rdata_idle: assert property (!req.rd |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");

  a_sample_start: assert property (sample_hold |-> dac_code == 8'h80)
    else $error("first trial code missing at sample");

  a_dac_idle: assert property (!active |=> dac_code == 8'h00 && !sample_hold)
    else $error("converter active while off or stopped");

  a_done_readback: assert property (req.rd && req.addr == `ADC_CTRL_OFFSET
    |=> bus_rdata[7] == $past(ctrl_q.done))
    else $error("done bit not visible in control read");

  a_unmapped_zero: assert property (req.rd && req.addr != `ADC_CTRL_OFFSET && req.addr != `ADC_RESULT_OFFSET
    |=> bus_rdata == 8'h00)
    else $error("unmapped read returned data");

  a_off_pins_free: assert property (!ctrl_q.converter_power_on |-> port_digital_en == 2'h3)
    else $error("pin taken while converter off");

  a_channel_take: assert property (ctrl_q.converter_power_on && analog_channel == 3'h1
    |-> port_digital_en == 2'h1)
    else $error("channel one did not take its pin");

  c_bus_done: cover property (conv_done && !ctrl_q.rc_clock_select);
  c_rc_done: cover property (conv_done && ctrl_q.rc_clock_select);
  c_stop_mid: cover property (state_q == adc_pkg::ST_RUN && cnt_q == 5'h04 && stop_mode);
  c_read_race: cover property (conv_done && result_rd);
  c_stop_release: cover property ($fell(stop_mode) && ctrl_q.converter_power_on);

endmodule : adc_control

// One shared port bit as a port data read sees it.
// The direction bit wins over the takeover, so an output pin still reads its latch.
module port_bit_read (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic taken,
  input wire logic ddr,
  input wire logic latch,
  input wire logic pin,
  output logic rd_q
);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_q <= 1'b0;
    end
    else if (ddr)
    begin
      rd_q <= latch;
    end
    else if (taken)
    begin
      rd_q <= 1'b0;
    end
    else
    begin
      rd_q <= pin;
    end
  end

endmodule : port_bit_read

// File: rtl/adc_pkg.sv
// Types shared by the converter control block.
package adc_pkg;

  typedef struct packed {
    logic done;
    logic rc_clock_select;
    logic converter_power_on;
    logic [1:0] unused;
    logic [2:0] input_channel_field;
  } ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [1:0] ddr;
    logic [1:0] latch;
    logic [1:0] pin;
  } shared_port_t;

  typedef enum logic {
    ST_OFF = 1'b0,
    ST_RUN = 1'b1
  } conv_state_t;

endpackage : adc_pkg

// File: rtl/adc_regs.svh
// Register offsets, field positions, reset values and timing counts of the converter control block.
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

`define ADC_ADDR_W 8
`define ADC_CTRL_OFFSET 8'h00
`define ADC_RESULT_OFFSET 8'h01

`define ADC_DONE_BIT 7
`define ADC_RC_BIT 6
`define ADC_ON_BIT 5
`define ADC_RSVD_MSB 4
`define ADC_RSVD_LSB 3
`define ADC_CH_MSB 2
`define ADC_CH_LSB 0

`define ADC_CTRL_RESET 8'h00
`define ADC_RESULT_RESET 8'h00

`define ADC_CONV_TICKS 32
`define ADC_LAST_TICK 5'h1F
`define ADC_FIRST_TICK 5'h00
`define ADC_SAR_STEPS 5'h08
`define ADC_SAR_FIRST 8'h80

`endif

// File: tb/adc_control_tb_top.sv
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module adc_control_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic stop_mode = 1'b0;
  logic rc_tick = 1'b0;
  logic [1:0] rc_div = 2'h0;
  logic rc_osc_enable;
  logic comparator_in;
  logic [7:0] ana_level = 8'h00;
  logic [7:0] dac_code;
  logic [2:0] analog_channel;
  logic sample_hold;
  logic [1:0] port_ddr = 2'h0;
  logic [1:0] port_latch = 2'h0;
  logic [1:0] port_pin = 2'h0;
  logic [1:0] port_read_data;
  logic [1:0] port_digital_en;
  int n_errors = 0;
  int checks = 0;
  logic [7:0] d;

  // An ideal comparator, so a correct search lands exactly on the input level.
  assign comparator_in = (ana_level >= dac_code);

  initial forever #20 clk = ~clk;

  // The RC tick runs four times slower than the bus clock, so the two modes are told apart.
  always @(posedge clk)
  begin
    rc_div <= rc_div + 2'h1;
    rc_tick <= (rc_div == 2'h3);
  end

  adc_control uut (.clk(clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .stop_mode(stop_mode), .rc_tick(rc_tick),
    .rc_osc_enable(rc_osc_enable), .comparator_in(comparator_in), .dac_code(dac_code),
    .analog_channel(analog_channel), .sample_hold(sample_hold), .port_ddr(port_ddr), .port_latch(port_latch),
    .port_pin(port_pin), .port_read_data(port_read_data), .port_digital_en(port_digital_en));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= v;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 v = bus_rdata;
  endtask : rd

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // Polling the control register never clears the flag, so it is safe to poll.
  task automatic wait_done(input int lim);
    logic [7:0] v;
    for (int i = 0; i < lim; i++)
    begin
      rd(8'h00, v);
      if (v[7] === 1'b1)
        return;
    end
    chk("done wait", 8'h00, 8'h01);
    wrap_up();
  endtask : wait_done

  task automatic t_reset();
    rd(8'h00, d);
    chk("control reset", d, 8'h00);
    rd(8'h01, d);
    chk("result reset", d, 8'h00);
    rd(8'h07, d);
    chk("unmapped read", d, 8'h00);
    chk("digital enable", {6'h00, port_digital_en}, 8'h03);
    $display("test reset finished");
  endtask : t_reset

  task automatic t_control();
    wr(8'h00, 8'hFF);
    rd(8'h00, d);
    chk("control readback", d, 8'h67);
    chk("channel out", {5'h00, analog_channel}, 8'h07);
    chk("rc enable", {7'h00, rc_osc_enable}, 8'h01);
    $display("test control finished");
  endtask : t_control

  task automatic t_conv();
    ana_level <= 8'h5A;
    wr(8'h00, 8'h20);
    repeat (2) @(posedge clk);
    #1 chk("sample pulse", {7'h00, sample_hold}, 8'h01);
    chk("first trial", dac_code, 8'h80);
    rd(8'h00, d);
    chk("done while running", d, 8'h20);
    chk("pin taken", {6'h00, port_digital_en}, 8'h02);
    wait_done(25);
    rd(8'h01, d);
    chk("result", d, 8'h5A);
    rd(8'h00, d);
    chk("done after result read", d, 8'h20);
    ana_level <= 8'hC3;
    repeat (70) @(posedge clk);
    rd(8'h00, d);
    chk("done repeats", d, 8'hA0);
    rd(8'h01, d);
    chk("result overwritten", d, 8'hC3);
    $display("test conversion finished");
  endtask : t_conv

  task automatic t_port();
    port_pin <= 2'h3;
    repeat (2) @(posedge clk);
    #1 chk("taken input", {6'h00, port_read_data}, 8'h02);
    port_ddr <= 2'h1;
    port_latch <= 2'h1;
    port_pin <= 2'h2;
    repeat (2) @(posedge clk);
    #1 chk("taken output", {6'h00, port_read_data}, 8'h03);
    port_ddr <= 2'h0;
    port_pin <= 2'h3;
    wr(8'h00, 8'h21);
    repeat (2) @(posedge clk);
    #1 chk("second pin", {4'h0, port_digital_en, port_read_data}, 8'h05);
    wr(8'h00, 8'h24);
    repeat (2) @(posedge clk);
    #1 chk("reference channel", {4'h0, port_digital_en, port_read_data}, 8'h0F);
    $display("test port finished");
  endtask : t_port

  task automatic t_stop();
    wr(8'h00, 8'h21);
    repeat (3) @(posedge clk);
    stop_mode <= 1'b1;
    repeat (60) @(posedge clk);
    rd(8'h00, d);
    chk("stopped", d, 8'h21);
    chk("stopped dac", dac_code, 8'h00);
    stop_mode <= 1'b0;
    wait_done(25);
    $display("test stop finished");
  endtask : t_stop

  // In RC mode a conversion needs 128 bus cycles, so a bus-clock count would finish too early.
  task automatic t_rc();
    wr(8'h00, 8'h60);
    #1 chk("rc on", {7'h00, rc_osc_enable}, 8'h01);
    repeat (40) @(posedge clk);
    rd(8'h00, d);
    chk("rc pace", d, 8'h60);
    wait_done(80);
    rd(8'h01, d);
    chk("rc result", d, 8'hC3);
    wait_done(80);
    wr(8'h00, 8'h00);
    rd(8'h00, d);
    chk("off clears done", d, 8'h00);
    chk("rc off", {7'h00, rc_osc_enable}, 8'h00);
    chk("pins free", {6'h00, port_digital_en}, 8'h03);
    $display("test rc finished");
  endtask : t_rc

  initial
  begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_control();
    t_conv();
    t_port();
    t_stop();
    t_rc();
    wrap_up();
  end
endmodule : adc_control_tb_top
